// ---- core/tioc_pkg.sv ----
/*
 * Constants, register map and field decoders for the timer I/O control block.
 * Assumes a 32-bit AXI4-Lite register bus and counters supplied by the timer unit.
 */
// Function
// - Bits 3 to 0 of each channel's I/O control register choose whether general register A compares or captures.
// - For channel 0 the low nibble of the second I/O control register chooses the function of register C.
// - A compare setting with bits 3 and 2 clear and an active action starts the pin low.
// - A compare setting with bit 3 clear, bit 2 set and an active action starts the pin high.
// - Action code 01 drives the pin low at every compare match.
// - Action code 10 drives the pin high at every compare match.
// - Action code 11 inverts the pin at every compare match.
// - A pin capture setting with bits 1:0 at 00 captures the counter on a rising pin edge.
// - A pin capture setting with bits 1:0 at 01 captures the counter on a falling pin edge.
// - A pin capture setting with bit 1 set captures the counter on both pin edges.
// - For channel 0, bits 3 and 2 set capture whenever channel 1's counter counts.
// - With the buffer bit of channel 0 set, register C neither captures nor drives its pin.
package tioc_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_UNITS = 4;
    localparam int U0A = 0;
    localparam int U0C = 1;
    localparam int U1A = 2;
    localparam int U2A = 3;

    localparam logic [7:0] OFS_CH0_CTRL_HIGH = 8'h00;
    localparam logic [7:0] OFS_CH0_CTRL_LOW = 8'h04;
    localparam logic [7:0] OFS_CH1_CTRL = 8'h08;
    localparam logic [7:0] OFS_CH2_CTRL = 8'h0c;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_GR0A = 8'h20;
    localparam logic [7:0] OFS_GR0C = 8'h24;
    localparam logic [7:0] OFS_GR1A = 8'h28;
    localparam logic [7:0] OFS_GR2A = 8'h2c;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int MODE_BUF_A_BIT = 0;

    localparam int BIT_CAPTURE = 3;
    localparam int BIT_LEVEL = 2;
    localparam int BIT_BOTH = 1;
    localparam int BIT_FALL = 0;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // True when a field makes its register drive the pin as a compare output.
    function automatic logic drives_pin(input logic [3:0] func);
        drives_pin = !func[BIT_CAPTURE] && (func[1:0] != ACT_NONE);
    endfunction

    // Maps a general register offset to its unit, or NUM_UNITS when it is none.
    function automatic int gr_unit(input logic [7:0] ofs);
        if (ofs == OFS_GR0A)
            gr_unit = U0A;
        else if (ofs == OFS_GR0C)
            gr_unit = U0C;
        else if (ofs == OFS_GR1A)
            gr_unit = U1A;
        else if (ofs == OFS_GR2A)
            gr_unit = U2A;
        else
            gr_unit = NUM_UNITS;
    endfunction
endpackage

// ---- core/tioc_unit.sv ----
/*
 * One general register with its compare output and capture input logic.
 * Assumes the counter and internal events come from logic on clk_sys; the pin is asynchronous.
 */
`timescale 1ns/1ps
module tioc_unit #(
    parameter int WIDTH = 16,
    parameter bit INT_SRC = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] func,
    input wire logic active,
    input wire logic [WIDTH-1:0] counter,
    input wire logic int_event,
    input wire logic sw_wr,
    input wire logic [WIDTH-1:0] sw_data,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic [WIDTH-1:0] gr,
    output logic event_out,
    output logic pin_level
);
    initial
    begin
        if (WIDTH < 1 || WIDTH > 32)
            $error("tioc_unit: WIDTH must lie between 1 and 32.");
    end

    logic sync1, sync2, sync3;
    logic [4:0] cfg_prev;
    logic [WIDTH-1:0] count_prev;
    logic cfg_chg, oc_mode, cap_mode, int_sel, pin_src, rise, fall, match, cap_hit;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end
        else
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A level change is accepted only once the last two stages agree, which filters a metastable sample.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pin_level <= 1'b0;
        else if (sync2 == sync3)
            pin_level <= sync3;
    end

    assign rise = (sync2 == sync3) && sync3 && !pin_level;
    assign fall = (sync2 == sync3) && !sync3 && pin_level;

    assign cfg_chg = cfg_prev != {active, func};
    assign oc_mode = active && !func[tioc_pkg::BIT_CAPTURE];
    assign cap_mode = active && func[tioc_pkg::BIT_CAPTURE];
    assign int_sel = INT_SRC && func[tioc_pkg::BIT_LEVEL];
    assign pin_src = cap_mode && !int_sel;

    always_comb
    begin
        cap_hit = 1'b0;
        if (cap_mode && int_sel)
            cap_hit = int_event;
        else if (cap_mode && func[tioc_pkg::BIT_BOTH])
            cap_hit = rise || fall;
        else if (cap_mode && func[tioc_pkg::BIT_FALL])
            cap_hit = fall;
        else if (cap_mode)
            cap_hit = rise;
    end

    // A match counts on the cycle the counter arrives at the value, so a slow count clock matches once.
    assign match = oc_mode && (counter != count_prev) && (counter == gr);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cfg_prev <= {1'b1, tioc_pkg::CTRL_RESET[3:0]};
            count_prev <= '0;
        end
        else
        begin
            cfg_prev <= {active, func};
            count_prev <= counter;
        end
    end

    // Capture wins over a software write in the same cycle so that no event is lost.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            gr <= '0;
        else if (cap_hit)
            gr <= counter;
        else if (sw_wr)
            gr <= sw_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pin_out <= 1'b0;
        else if (cfg_chg && oc_mode && func[1:0] != tioc_pkg::ACT_NONE)
            pin_out <= func[tioc_pkg::BIT_LEVEL];
        else if (match)
        begin
            case (func[1:0])
                tioc_pkg::ACT_LOW: pin_out <= 1'b0;
                tioc_pkg::ACT_HIGH: pin_out <= 1'b1;
                tioc_pkg::ACT_TOGGLE: pin_out <= !pin_out;
                default: pin_out <= pin_out;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_oe_n <= 1'b1;
            event_out <= 1'b0;
        end
        else
        begin
            pin_oe_n <= !(active && tioc_pkg::drives_pin(func));
            event_out <= match || cap_hit;
        end
    end

    property p_init_low;
        @(posedge clk_sys) disable iff (reset)
        cfg_chg && oc_mode && !func[2] && func[1:0] != 2'h0 |=> !pin_out;
    endproperty
    a_init_low: assert property (p_init_low) else $error("Initial compare level not low.");

    property p_init_high;
        @(posedge clk_sys) disable iff (reset)
        cfg_chg && oc_mode && func[2] && func[1:0] != 2'h0 |=> pin_out && !pin_oe_n;
    endproperty
    a_init_high: assert property (p_init_high) else $error("Initial compare level not high or pin undriven.");

    property p_match_low;
        @(posedge clk_sys) disable iff (reset)
        oc_mode && !cfg_chg && func[1:0] == 2'h1 && counter == gr && counter != $past(counter) |=> !pin_out;
    endproperty
    a_match_low: assert property (p_match_low) else $error("Pin not low after match.");

    property p_match_high;
        @(posedge clk_sys) disable iff (reset)
        oc_mode && !cfg_chg && func[1:0] == 2'h2 && counter == gr && counter != $past(counter) |=> pin_out;
    endproperty
    a_match_high: assert property (p_match_high) else $error("Pin not high after match.");

    property p_match_toggle;
        @(posedge clk_sys) disable iff (reset)
        oc_mode && !cfg_chg && func[1:0] == 2'h3 && counter == gr && counter != $past(counter)
            |=> pin_out != $past(pin_out) && event_out;
    endproperty
    a_match_toggle: assert property (p_match_toggle) else $error("Pin did not invert after match.");

    property p_cap_rise;
        @(posedge clk_sys) disable iff (reset)
        pin_src && func[1:0] == 2'h0 && $rose(pin_level) |-> gr == $past(counter);
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("No capture at rising edge.");

    property p_cap_fall;
        @(posedge clk_sys) disable iff (reset)
        pin_src && func[1:0] == 2'h1 && $fell(pin_level) |-> gr == $past(counter);
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("No capture at falling edge.");

    property p_cap_both;
        @(posedge clk_sys) disable iff (reset)
        pin_src && func[1] && pin_level != $past(pin_level) |-> gr == $past(counter) && event_out;
    endproperty
    a_cap_both: assert property (p_cap_both) else $error("No capture at pin edge in both-edge mode.");

    property p_cap_internal;
        @(posedge clk_sys) disable iff (reset)
        cap_mode && int_sel && int_event |=> gr == $past(counter) && event_out;
    endproperty
    a_cap_internal: assert property (p_cap_internal) else $error("No capture at internal event.");
endmodule

// ---- core/tioc_top.sv ----
/*
 * Timer I/O control block: AXI4-Lite register bank and four general register units.
 * Assumes the timer unit supplies the channel counters and channel 1's count event on clk_sys.
 */
`timescale 1ns/1ps
module tioc_top #(
    parameter int TIMER_W = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [tioc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tioc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [TIMER_W-1:0] chan0_counter,
    input wire logic [TIMER_W-1:0] chan1_counter,
    input wire logic [TIMER_W-1:0] chan2_counter,
    input wire logic chan1_count_tick,
    input wire logic chan0_pin_a_in,
    output logic chan0_pin_a_out,
    output logic chan0_pin_a_oe_n,
    input wire logic chan0_pin_c_in,
    output logic chan0_pin_c_out,
    output logic chan0_pin_c_oe_n,
    input wire logic chan1_pin_a_in,
    output logic chan1_pin_a_out,
    output logic chan1_pin_a_oe_n,
    input wire logic chan2_pin_a_in,
    output logic chan2_pin_a_out,
    output logic chan2_pin_a_oe_n
);
    localparam int N = tioc_pkg::NUM_UNITS;

    initial
    begin
        if (TIMER_W < 9 || TIMER_W > 16)
            $error("tioc_top: TIMER_W must lie between 9 and 16.");
    end

    logic [N-1:0][7:0] io_ctrl;
    logic [7:0] chan0_mode_reg;
    logic [N-1:0][3:0] func;
    logic [N-1:0] active, int_event, sw_wr, pin_in, pin_out, pin_oe_n, event_out, pin_level;
    logic [N-1:0][TIMER_W-1:0] counter, gr;
    logic [TIMER_W-1:0] gr_wdata;
    logic [tioc_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_full, w_full, do_write;
    int wr_unit;

    // Each control field is the low nibble of its own register; channel 0 has a second one for register C.
    always_comb
    begin
        for (int i = 0; i < N; i++)
            func[i] = io_ctrl[i][3:0];
    end

    // Register C goes silent while it serves as the buffer of register A.
    assign active = {1'b1, 1'b1, !chan0_mode_reg[tioc_pkg::MODE_BUF_A_BIT], 1'b1};
    // Channel 0 counts channel 1's clock; channel 1 follows channel 0 register A; channel 2 has no source.
    assign int_event = {1'b0, event_out[tioc_pkg::U0A], chan1_count_tick, chan1_count_tick};
    assign counter = {chan2_counter, chan1_counter, chan0_counter, chan0_counter};
    assign pin_in = {chan2_pin_a_in, chan1_pin_a_in, chan0_pin_c_in, chan0_pin_a_in};

    assign chan0_pin_a_out = pin_out[tioc_pkg::U0A];
    assign chan0_pin_a_oe_n = pin_oe_n[tioc_pkg::U0A];
    assign chan0_pin_c_out = pin_out[tioc_pkg::U0C];
    assign chan0_pin_c_oe_n = pin_oe_n[tioc_pkg::U0C];
    assign chan1_pin_a_out = pin_out[tioc_pkg::U1A];
    assign chan1_pin_a_oe_n = pin_oe_n[tioc_pkg::U1A];
    assign chan2_pin_a_out = pin_out[tioc_pkg::U2A];
    assign chan2_pin_a_oe_n = pin_oe_n[tioc_pkg::U2A];

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_unit
            tioc_unit #(
                .WIDTH(TIMER_W),
                .INT_SRC(g != tioc_pkg::U2A)
            ) u_unit (
                .clk_sys(clk_sys),
                .reset(reset),
                .func(func[g]),
                .active(active[g]),
                .counter(counter[g]),
                .int_event(int_event[g]),
                .sw_wr(sw_wr[g]),
                .sw_data(gr_wdata),
                .pin_in(pin_in[g]),
                .pin_out(pin_out[g]),
                .pin_oe_n(pin_oe_n[g]),
                .gr(gr[g]),
                .event_out(event_out[g]),
                .pin_level(pin_level[g])
            );
        end
    endgenerate

    // Address and data are held separately so the master may present them in either order.
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_unit = tioc_pkg::gr_unit(aw_addr);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_full <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_full <= 1'b0;
    end

    // Unwritten byte lanes keep the register's present value.
    always_comb
    begin
        gr_wdata = '0;
        for (int i = 0; i < N; i++)
        begin
            if (wr_unit == i)
                gr_wdata = gr[i];
        end
        if (w_strb[0])
            gr_wdata[7:0] = w_data[7:0];
        if (w_strb[1])
            gr_wdata[TIMER_W-1:8] = w_data[TIMER_W-1:8];
    end

    always_comb
    begin
        for (int i = 0; i < N; i++)
            sw_wr[i] = do_write && (wr_unit == i);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            io_ctrl <= {N{tioc_pkg::CTRL_RESET}};
            chan0_mode_reg <= tioc_pkg::MODE_RESET;
        end
        else if (do_write && w_strb[0])
        begin
            if (aw_addr == tioc_pkg::OFS_CH0_CTRL_HIGH)
                io_ctrl[tioc_pkg::U0A] <= w_data[7:0];
            else if (aw_addr == tioc_pkg::OFS_CH0_CTRL_LOW)
                io_ctrl[tioc_pkg::U0C] <= w_data[7:0];
            else if (aw_addr == tioc_pkg::OFS_CH1_CTRL)
                io_ctrl[tioc_pkg::U1A] <= w_data[7:0];
            else if (aw_addr == tioc_pkg::OFS_CH2_CTRL)
                io_ctrl[tioc_pkg::U2A] <= w_data[7:0];
            else if (aw_addr == tioc_pkg::OFS_MODE)
                chan0_mode_reg <= w_data[7:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tioc_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == tioc_pkg::OFS_CH0_CTRL_HIGH || aw_addr == tioc_pkg::OFS_CH0_CTRL_LOW ||
                aw_addr == tioc_pkg::OFS_CH1_CTRL || aw_addr == tioc_pkg::OFS_CH2_CTRL ||
                aw_addr == tioc_pkg::OFS_MODE || aw_addr == tioc_pkg::OFS_STATUS || wr_unit != N)
                s_axi_bresp <= tioc_pkg::RESP_OKAY;
            else
                s_axi_bresp <= tioc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= tioc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tioc_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
            if (s_axi_araddr == tioc_pkg::OFS_CH0_CTRL_HIGH)
                s_axi_rdata[7:0] <= io_ctrl[tioc_pkg::U0A];
            else if (s_axi_araddr == tioc_pkg::OFS_CH0_CTRL_LOW)
                s_axi_rdata[7:0] <= io_ctrl[tioc_pkg::U0C];
            else if (s_axi_araddr == tioc_pkg::OFS_CH1_CTRL)
                s_axi_rdata[7:0] <= io_ctrl[tioc_pkg::U1A];
            else if (s_axi_araddr == tioc_pkg::OFS_CH2_CTRL)
                s_axi_rdata[7:0] <= io_ctrl[tioc_pkg::U2A];
            else if (s_axi_araddr == tioc_pkg::OFS_MODE)
                s_axi_rdata[7:0] <= chan0_mode_reg;
            else if (s_axi_araddr == tioc_pkg::OFS_STATUS)
                s_axi_rdata[11:0] <= {~pin_oe_n, pin_out, pin_level};
            else if (tioc_pkg::gr_unit(s_axi_araddr) != N)
                s_axi_rdata[TIMER_W-1:0] <= gr[tioc_pkg::gr_unit(s_axi_araddr)];
            else
                s_axi_rresp <= tioc_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    property p_ctrl_field;
        @(posedge clk_sys) disable iff (reset)
        do_write && w_strb[0] && aw_addr == tioc_pkg::OFS_CH1_CTRL |=> func[2] == $past(w_data[3:0]);
    endproperty
    a_ctrl_field: assert property (p_ctrl_field) else $error("Channel 1 field not taken from bits 3 to 0.");

    property p_ctrl_c;
        @(posedge clk_sys) disable iff (reset)
        do_write && w_strb[0] && aw_addr == tioc_pkg::OFS_CH0_CTRL_LOW |=> func[1] == $past(w_data[3:0]);
    endproperty
    a_ctrl_c: assert property (p_ctrl_c) else $error("Register C field not taken from second register.");

    property p_buffer_silent;
        @(posedge clk_sys) disable iff (reset)
        chan0_mode_reg[tioc_pkg::MODE_BUF_A_BIT] [*2] |-> chan0_pin_c_oe_n && ($stable(gr[1]) || $past(sw_wr[1]));
    endproperty
    a_buffer_silent: assert property (p_buffer_silent) else $error("Buffered register C still active.");

    property p_follow_a;
        @(posedge clk_sys) disable iff (reset)
        event_out[0] && active[2] && func[2][3:2] == 2'h3 |=> gr[2] == $past(chan1_counter);
    endproperty
    a_follow_a: assert property (p_follow_a) else $error("Channel 1 missed channel 0 register A event.");

    property p_disabled_codes;
        @(posedge clk_sys) disable iff (reset)
        (func[3] == 4'h0 || func[3] == 4'h4) [*2] |-> chan2_pin_a_oe_n;
    endproperty
    a_disabled_codes: assert property (p_disabled_codes) else $error("Pin driven under a disabled code.");
endmodule

// ---- tb/tioc_pin_model.sv ----
/*
 * Pads of the four timer pins as seen from outside the block.
 * Assumes the bench offers the outside level on ext; a driven pad reads back its own output.
 */
`timescale 1ns/1ps
module tioc_pin_model (
    input wire logic [3:0] ext,
    input wire logic [3:0] out,
    input wire logic [3:0] oe_n,
    output logic [3:0] pin
);
    // Outside circuitry only sets a pad that the block has released.
    assign pin = (oe_n & ext) | (~oe_n & out);
endmodule

// ---- tb/tb_timer_io_control_low_nibble.sv ----
/*
 * Self-checking bench of the timer I/O control block: AXI4-Lite master, counter and pin stimulus.
 * Assumes the design files under core/ and the pin model; one clock, synchronous reset.
 */
`timescale 1ns/1ps
module tb_timer_io_control_low_nibble;
    logic clk_sys = 0;
    logic reset = 1;
    logic [7:0] awaddr = 0;
    logic [7:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0;
    logic wvalid = 0;
    logic bready = 0;
    logic arvalid = 0;
    logic rready = 0;
    logic tick = 0;
    logic [15:0] cnt = 0;
    logic [3:0] ext = 0;
    logic [3:0] pout, poe_n, pin;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] exp_q[$];
    logic [15:0] v1, v2, g;
    logic [3:0] c;
    int fails = 0;
    int tests_run = 0;
    int seed = 32'h58d9;

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    tioc_top dut (.clk_sys(clk_sys), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chan0_counter(cnt), .chan1_counter(cnt), .chan2_counter(cnt), .chan1_count_tick(tick),
        .chan0_pin_a_in(pin[0]), .chan0_pin_a_out(pout[0]), .chan0_pin_a_oe_n(poe_n[0]),
        .chan0_pin_c_in(pin[1]), .chan0_pin_c_out(pout[1]), .chan0_pin_c_oe_n(poe_n[1]),
        .chan1_pin_a_in(pin[2]), .chan1_pin_a_out(pout[2]), .chan1_pin_a_oe_n(poe_n[2]),
        .chan2_pin_a_in(pin[3]), .chan2_pin_a_out(pout[3]), .chan2_pin_a_oe_n(poe_n[3]));
    tioc_pin_model pads (.ext(ext), .out(pout), .oe_n(poe_n), .pin(pin));

    task automatic check(input string what, input logic [33:0] e, input logic [33:0] s);
        tests_run++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic bail(input logic ok);
        if (!ok)
        begin
            fails++;
            complete_run();
        end
    endtask

    // Values read right after an edge are still those the edge sampled.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic b;
        n = 0;
        b = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b && n < 60)
        begin
            @(posedge clk_sys);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid)
            begin
                b = 1;
                check("bresp", {32'h0, er}, {32'h0, bresp});
            end
        end
        bail(b);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        logic r;
        n = 0;
        r = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        exp_q.push_back(e);
        while (!r && n < 60)
        begin
            @(posedge clk_sys);
            n++;
            if (arready) arvalid <= 0;
            if (rvalid) r = 1;
        end
        bail(r);
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys) cnt <= cnt + 16'h1;
    endtask

    always @(posedge clk_sys)
        if (rvalid === 1'b1 && rready === 1'b1)
            check("read", exp_q.pop_front(), {rresp, rdata});

    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 0;
        @(posedge clk_sys);
        for (int k = 0; k < 6; k++)
            rd(8'(4 * k), 34'h0);
        check("oe_n", 34'hf, {30'h0, poe_n});
        rd(8'h3c, {tioc_pkg::RESP_SLVERR, 32'h0});
        wr(8'h3c, 32'h1, tioc_pkg::RESP_SLVERR);
        $display("test reset and map done");
        for (int k = 0; k < 8; k++)
        begin
            c = 4'(k);
            g = 16'(($random(seed) & 31) + 1);
            cnt <= 0;
            for (int j = 0; j < 4; j += (j == 0) ? 2 : 1)
            begin
                wr(8'h20 + 8'(4 * j), {16'h0, g}, 2'h0);
                wr(8'(4 * j), {28'h0, c}, 2'h0);
            end
            repeat (2) @(posedge clk_sys);
            for (int j = 0; j < 4; j += (j == 0) ? 2 : 1)
            begin
                check("oe_n", {33'h0, c[1:0] == 0}, {33'h0, poe_n[j]});
                if (c[1:0] != 0) check("init", {33'h0, c[2]}, {33'h0, pout[j]});
            end
            step(g);
            repeat (2) @(posedge clk_sys);
            for (int j = 0; j < 4; j += (j == 0) ? 2 : 1)
            begin
                if (c[1:0] != 0)
                    check("match", {33'h0, c[1:0] == 3 ? !c[2] : c[1]}, {33'h0, pout[j]});
            end
        end
        wr(8'h04, 32'h5, 2'h0);
        repeat (2) @(posedge clk_sys);
        check("c init", 34'h1, {33'h0, pout[1]});
        wr(8'h10, 32'h1, 2'h0);
        repeat (2) @(posedge clk_sys);
        check("c silenced", 34'h1, {33'h0, poe_n[1]});
        wr(8'h10, 32'h0, 2'h0);
        $display("test compare done");
        for (int k = 0; k < 6; k++)
        begin
            c = 4'(8 + k % 3 + (k / 3) * 4);
            v1 = 16'($random(seed));
            v2 = ~v1;
            cnt <= v1;
            wr(8'h08 + 8'(4 * (k / 3)), {28'h0, c}, 2'h0);
            wr(8'h28 + 8'(4 * (k / 3)), 32'h0, 2'h0);
            ext[2 + k / 3] <= 1;
            repeat (8) @(posedge clk_sys);
            g = (c[1:0] == 1) ? 16'h0 : v1;
            rd(8'h28 + 8'(4 * (k / 3)), {18'h0, g});
            cnt <= v2;
            ext[2 + k / 3] <= 0;
            repeat (8) @(posedge clk_sys);
            g = (c[1:0] == 0) ? v1 : v2;
            rd(8'h28 + 8'(4 * (k / 3)), {18'h0, g});
        end
        v1 = 16'($random(seed));
        wr(8'h00, 32'hc, 2'h0);
        wr(8'h08, 32'hc, 2'h0);
        cnt <= v1;
        @(posedge clk_sys);
        tick <= 1;
        @(posedge clk_sys);
        tick <= 0;
        repeat (4) @(posedge clk_sys);
        rd(8'h20, {18'h0, v1});
        rd(8'h28, {18'h0, v1});
        $display("test capture done");
        complete_run();
    end
endmodule
